// ### core/bsi_pkg.sv
/*
 * constants and types for the slave interrupt enable register block:
 * register offsets, field positions, reset values and the enable layout.
 * assumes a 32-bit classic wishbone slave with byte addresses.
 */
package bsi_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_SRC = 7;

	// byte offsets, one aligned word each
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_LINE_EN = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// field positions of the enable register
	localparam int unsigned BIT_RESET_READ_GATE = 7;
	localparam int unsigned BIT_BT_RESET = 6;
	localparam int unsigned BIT_HOST_IRQ_CLEAR = 5;
	localparam int unsigned BIT_EVENT_ATTN_CLEAR = 4;
	localparam int unsigned BIT_READ_END = 3;
	localparam int unsigned BIT_WRITE_END = 2;
	localparam int unsigned BIT_RD_PTR_CLEAR = 1;
	localparam int unsigned BIT_WR_PTR_CLEAR = 0;

	// field positions of the status register
	localparam int unsigned STS_IRQ = 0;
	localparam int unsigned STS_HOST_VIEW = 1;
	localparam int unsigned STS_RAW_RESET = 2;

	// values after reset
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic LINE_EN_RST = 1'b0;
	localparam logic [NUM_SRC-1:0] FLAGS_RST = 7'h00;

	typedef struct packed {
		logic reset_read_gate;
		logic bt_reset_irq_en;
		logic host_irq_clear_irq_en;
		logic event_attn_clear_irq_en;
		logic read_end_irq_en;
		logic write_end_irq_en;
		logic rd_ptr_clear_irq_en;
		logic wr_ptr_clear_irq_en;
	} bsi_enable_t;

endpackage : bsi_pkg

// ### core/bsi_slave_irq_enable.sv
/*
 * slave interrupt enable register with source flags, line enable and
 * the gate on the host view of the slave hardware reset status.
 * assumes a classic wishbone master on clk_i and one-cycle source pulses.
 */
// What this block does
// RULE_01 - shared slave interrupt rises only while software sets the line enable
// RULE_02 - gate bit 7 resets 0; at 0 host sees reset status 0
// RULE_03 - bit 6 resets 0, enables or masks the reset interrupt source
// RULE_04 - bit 5 resets 0, enables or masks the host request clear source
// RULE_05 - bit 4 resets 0, enables or masks the event attention clear source
// RULE_06 - bit 3 resets 0, enables or masks the host read end source
// RULE_07 - bit 2 resets 0, enables or masks the host write end source
// RULE_08 - bit 1 resets 0, enables or masks the read pointer clear source
// RULE_09 - interrupt asserts while line enabled and any enabled flag set; host cannot access
`timescale 1ns/1ps
module bsi_slave_irq_enable #(
	parameter int unsigned SRC_W = bsi_pkg::NUM_SRC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [bsi_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [bsi_pkg::DATA_W-1:0] wb_dat_i,
	output logic [bsi_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [SRC_W-1:0] src_event_i,
	input wire logic slave_hw_reset_i,
	output logic shared_slave_irq_o,
	output logic slave_hw_reset_status_o
);

	// the flag layout follows the enable fields one to one
	if (SRC_W != bsi_pkg::NUM_SRC) begin : g_bad_src_w
		$error("SRC_W must equal the number of enable fields");
	end

	logic ack_r;
	logic ack_nxt;
	logic [bsi_pkg::DATA_W-1:0] dat_r;
	logic [bsi_pkg::DATA_W-1:0] dat_nxt;
	logic take;
	logic wr;
	logic wr_enable;
	logic wr_line;
	logic wr_flags;
	logic mapped;
	logic [7:0] ofs;

	bsi_pkg::bsi_enable_t en_r;
	bsi_pkg::bsi_enable_t en_nxt;
	logic line_en_r;
	logic line_en_nxt;

	logic [SRC_W-1:0] flag_r;
	logic [SRC_W-1:0] flag_nxt;
	logic [SRC_W-1:0] en_src;

	logic irq_r;
	logic irq_nxt;
	logic host_view_r;
	logic host_view_nxt;

	// bus group: every access is answered one cycle after it appears
	always_comb begin
		ofs = {wb_adr_i[7:2], 2'b00};
		ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
		take = ack_nxt;
		wr = take & wb_we_i & wb_sel_i[0];
		mapped = 1'b1;
		wr_enable = 1'b0;
		wr_line = 1'b0;
		wr_flags = 1'b0;
		dat_nxt = dat_r;
		case (ofs)
			bsi_pkg::OFS_ENABLE: begin
				wr_enable = wr;
			end
			bsi_pkg::OFS_LINE_EN: begin
				wr_line = wr;
			end
			bsi_pkg::OFS_FLAGS: begin
				wr_flags = wr;
			end
			bsi_pkg::OFS_STATUS: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (take) begin
			dat_nxt = 32'h0000_0000;
			if (mapped && !wb_we_i) begin
				case (ofs)
					bsi_pkg::OFS_ENABLE: begin
						dat_nxt[7:0] = en_r;
					end
					bsi_pkg::OFS_LINE_EN: begin
						dat_nxt[0] = line_en_r;
					end
					bsi_pkg::OFS_FLAGS: begin
						dat_nxt[SRC_W-1:0] = flag_r;
					end
					default: begin
						dat_nxt[bsi_pkg::STS_IRQ] = irq_r;
						dat_nxt[bsi_pkg::STS_HOST_VIEW] = host_view_r;
						dat_nxt[bsi_pkg::STS_RAW_RESET] = slave_hw_reset_i;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// control group: only the local bus reaches these, no host port exists
	always_comb begin
		en_nxt = en_r;
		line_en_nxt = line_en_r;
		if (wr_enable) begin
			en_nxt = bsi_pkg::bsi_enable_t'(wb_dat_i[7:0]); // RULE_09
		end
		if (wr_line) begin
			line_en_nxt = wb_dat_i[0]; // RULE_01
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_r <= bsi_pkg::ENABLE_RST; // RULE_03
			line_en_r <= bsi_pkg::LINE_EN_RST;
		end else begin
			en_r <= en_nxt;
			line_en_r <= line_en_nxt;
		end
	end

	// flags: write 0 clears, an event in the same cycle still sets
	for (genvar g = 0; g < SRC_W; g++) begin : g_flag
		always_comb begin
			flag_nxt[g] = (flag_r[g] & ~(wr_flags & ~wb_dat_i[g])) | src_event_i[g];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_r <= bsi_pkg::FLAGS_RST;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// output group: registered, so each output lags its cause by one cycle
	always_comb begin
		en_src = en_r[SRC_W-1:0]; // RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08
		irq_nxt = line_en_r & (|(flag_r & en_src)); // RULE_01 RULE_09
		host_view_nxt = slave_hw_reset_i & en_r.reset_read_gate; // RULE_02
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
			host_view_r <= 1'b0; // RULE_02
		end else begin
			irq_r <= irq_nxt;
			host_view_r <= host_view_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign shared_slave_irq_o = irq_r;
	assign slave_hw_reset_status_o = host_view_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_irq_needs_line: assert property ( // RULE_01
		shared_slave_irq_o |-> $past(line_en_r)
	) else $error("interrupt raised with line enable off");

	a_gate_hides_reset: assert property ( // RULE_02
		!$past(en_r.reset_read_gate) |-> !slave_hw_reset_status_o
	) else $error("host saw reset status while gate closed");

	a_gate_shows_reset: assert property ( // RULE_02
		$past(en_r.reset_read_gate) && $past(slave_hw_reset_i) |-> slave_hw_reset_status_o
	) else $error("host view missed reset status with gate open");

	a_bt_reset_src: assert property ( // RULE_03
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_BT_RESET]) && $past(en_r.bt_reset_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled reset source did not raise interrupt");

	a_host_clr_src: assert property ( // RULE_04
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_HOST_IRQ_CLEAR]) && $past(en_r.host_irq_clear_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled host request clear source did not raise interrupt");

	a_attn_clr_src: assert property ( // RULE_05
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_EVENT_ATTN_CLEAR]) && $past(en_r.event_attn_clear_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled attention clear source did not raise interrupt");

	a_read_end_src: assert property ( // RULE_06
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_READ_END]) && $past(en_r.read_end_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled read end source did not raise interrupt");

	a_write_end_src: assert property ( // RULE_07
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_WRITE_END]) && $past(en_r.write_end_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled write end source did not raise interrupt");

	a_rd_ptr_src: assert property ( // RULE_08
		$past(line_en_r) && $past(flag_r[bsi_pkg::BIT_RD_PTR_CLEAR]) && $past(en_r.rd_ptr_clear_irq_en)
		|-> shared_slave_irq_o
	) else $error("enabled read pointer clear source did not raise interrupt");

	a_irq_has_cause: assert property ( // RULE_09
		shared_slave_irq_o |-> |($past(flag_r) & $past(en_src))
	) else $error("interrupt raised without an enabled flag");

	a_masked_quiet: assert property ( // RULE_09
		($past(en_src) == 7'h00) [*2] |-> !shared_slave_irq_o
	) else $error("interrupt raised with every source masked");

	for (genvar g = 0; g < SRC_W; g++) begin : g_flag_chk
		a_event_sets_flag: assert property ( // RULE_09
			src_event_i[g] |=> flag_r[g]
		) else $error("source event lost");
		a_zero_clears_flag: assert property ( // RULE_09
			(wr_flags && !wb_dat_i[g] && !src_event_i[g]) |=> !flag_r[g]
		) else $error("zero write did not clear the flag");
		a_one_keeps_flag: assert property ( // RULE_09
			(wr_flags && wb_dat_i[g] && flag_r[g]) |=> flag_r[g]
		) else $error("one write cleared the flag");
	end

	a_enable_write_lands: assert property ( // RULE_09
		(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && ofs == bsi_pkg::OFS_ENABLE)
		|=> en_r == $past(wb_dat_i[7:0]) && wb_ack_o
	) else $error("enable write did not land with its acknowledge");

	a_ack_answers: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o
	) else $error("acknowledge not a single cycle after request");

	// writes land on the taking edge, read data stands with the acknowledge
	a_line_write_lands: assert property ( // RULE_01
		(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && ofs == bsi_pkg::OFS_LINE_EN)
		|=> line_en_r == $past(wb_dat_i[0]) && wb_ack_o
	) else $error("line enable write did not land with its acknowledge");

	a_sel_guards_write: assert property ( // RULE_09
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_sel_i[0]) |=> $stable(en_r) && $stable(line_en_r)
	) else $error("write without low byte select changed a register");

	a_status_read: assert property ( // RULE_02
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && ofs == bsi_pkg::OFS_STATUS)
		|=> wb_dat_o[bsi_pkg::STS_HOST_VIEW] == $past(slave_hw_reset_status_o)
	) else $error("status read disagrees with host view");

	a_unmapped_zero: assert property ( // RULE_09
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !mapped) |=> wb_dat_o == 32'h0000_0000
	) else $error("unmapped access returned data");

	c_irq_rise: cover property (
		!shared_slave_irq_o ##1 shared_slave_irq_o
	);

	c_sel_blocked: cover property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]
	);

	c_host_sees_reset: cover property (
		slave_hw_reset_status_o
	);

	c_set_meets_clear: cover property (
		wr_flags && !wb_dat_i[0] && src_event_i[0]
	);

	c_masked_flag: cover property (
		line_en_r && (|flag_r) && !(|(flag_r & en_src)) [*3]
	);

endmodule : bsi_slave_irq_enable

// ### test/bsi_far_model.sv
/*
 * far side model: slave-side event sources and the raw slave reset level.
 * assumes clk_i is the block clock and one-cycle event pulses.
 */
`timescale 1ns/1ps
module bsi_far_model (
	input wire logic clk_i,
	output logic [6:0] src_event_o,
	output logic slave_hw_reset_o
);
	initial begin
		src_event_o = 7'h00;
		slave_hw_reset_o = 1'b0;
	end
	// single-cycle pulse; a longer one would only re-set the flag
	task automatic pulse(input int g);
		@(posedge clk_i);
		src_event_o <= 7'(1 << g);
		@(posedge clk_i);
		src_event_o <= 7'h00;
	endtask : pulse
	task automatic level(input logic v);
		@(posedge clk_i);
		slave_hw_reset_o <= v;
	endtask : level
endmodule : bsi_far_model

// ### test/bt_slave_irq_enable_one_tb_top.sv
/*
 * testbench for the slave interrupt enable block over classic wishbone.
 * assumes the register map of the block's package and the block's one-cycle acknowledge.
 */
`timescale 1ns/1ps
module bt_slave_irq_enable_one_tb_top;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, sts, hw;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, dat_o, q;
	logic [6:0] ev;
	int n_errors = 0;
	int checked = 0;
	always #12.5 clk_i = ~clk_i;
	bsi_slave_irq_enable #(.SRC_W(bsi_pkg::NUM_SRC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .src_event_i(ev), .slave_hw_reset_i(hw), .shared_slave_irq_o(irq),
		.slave_hw_reset_status_o(sts));
	bsi_far_model i_far (.clk_i(clk_i), .src_event_o(ev), .slave_hw_reset_o(hw));
	task automatic results();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// held until ack is sampled, then released for at least one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			results();
		end
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'hf;
		dat = 32'h0000_0000;
		idle(3);
		rst_i <= 1'b0;
		idle(1);
		chk("irq after reset", 32'h0000_0000, 32'(irq));
		wb(1'b0, bsi_pkg::OFS_ENABLE, 32'h0000_0000, q);
		chk("enable reset", 32'h0000_0000, q);
		for (int g = 0; g < 7; g++) begin
			wb(1'b1, bsi_pkg::OFS_ENABLE, 32'(1 << g), q);
			i_far.pulse(g);
			idle(3);
			chk("irq line off", 32'h0000_0000, 32'(irq));
			wb(1'b1, bsi_pkg::OFS_LINE_EN, 32'h0000_0001, q);
			i_far.pulse((g + 1) % 7);
			idle(3);
			chk("irq enabled", 32'h0000_0001, 32'(irq));
			wb(1'b1, bsi_pkg::OFS_ENABLE, 32'(1 << ((g + 1) % 7)), q);
			wb(1'b1, bsi_pkg::OFS_FLAGS, 32'(1 << g), q);
			idle(3);
			chk("irq masked", 32'h0000_0000, 32'(irq));
			wb(1'b1, bsi_pkg::OFS_FLAGS, 32'h0000_0000, q);
			wb(1'b1, bsi_pkg::OFS_LINE_EN, 32'h0000_0000, q);
		end
		i_far.level(1'b1);
		idle(3);
		chk("host view gated", 32'h0000_0000, 32'(sts));
		wb(1'b1, bsi_pkg::OFS_ENABLE, 32'h0000_0080, q);
		idle(3);
		chk("host view open", 32'h0000_0001, 32'(sts));
		wb(1'b0, 8'h10, 32'h0000_0000, q);
		chk("unmapped read", 32'h0000_0000, q);
		wb(1'b0, bsi_pkg::OFS_STATUS, 32'h0000_0000, q);
		chk("status read", 32'h0000_0006, q);
		wb(1'b1, bsi_pkg::OFS_LINE_EN, 32'h0000_0001, q);
		wb(1'b0, bsi_pkg::OFS_LINE_EN, 32'h0000_0000, q);
		chk("line enable read", 32'h0000_0001, q);
		// low byte not selected: the write must be ignored
		sel <= 4'he;
		wb(1'b1, bsi_pkg::OFS_LINE_EN, 32'h0000_0000, q);
		sel <= 4'hf;
		wb(1'b0, bsi_pkg::OFS_LINE_EN, 32'h0000_0000, q);
		chk("line kept without sel", 32'h0000_0001, q);
		// event and zero write on the same edge: the set wins
		fork
			i_far.pulse(0);
			wb(1'b1, bsi_pkg::OFS_FLAGS, 32'h0000_0000, q);
		join
		wb(1'b0, bsi_pkg::OFS_FLAGS, 32'h0000_0000, q);
		chk("set beats clear", 32'h0000_0001, q);
		wb(1'b1, bsi_pkg::OFS_ENABLE, 32'h0000_0081, q);
		idle(2);
		wb(1'b0, bsi_pkg::OFS_STATUS, 32'h0000_0000, q);
		chk("status irq", 32'h0000_0007, q);
		rst_i <= 1'b1;
		idle(2);
		rst_i <= 1'b0;
		idle(1);
		chk("irq after second reset", 32'h0000_0000, 32'(irq));
		chk("host view after second reset", 32'h0000_0000, 32'(sts));
		wb(1'b0, bsi_pkg::OFS_STATUS, 32'h0000_0000, q);
		chk("status after second reset", 32'h0000_0004, q);
		wb(1'b0, bsi_pkg::OFS_ENABLE, 32'h0000_0000, q);
		chk("enable after second reset", 32'h0000_0000, q);
		wb(1'b0, bsi_pkg::OFS_FLAGS, 32'h0000_0000, q);
		chk("flags after second reset", 32'h0000_0000, q);
		results();
	end
endmodule : bt_slave_irq_enable_one_tb_top
